// File: dcbmf_pkg.sv
// Constants shared by the dual-clock bus-matching FIFO controller
package dcbmf_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [11:0] ADDR_CONFIG = 12'h000;
  localparam logic [11:0] ADDR_EMPTY_OFS = 12'h004;
  localparam logic [11:0] ADDR_FULL_OFS = 12'h008;
  localparam logic [11:0] ADDR_STATUS = 12'h00C;
  // ----------------------------------------
  // Reset values and widths
  // ----------------------------------------
  localparam int EMPTY_OFS_RST = 127;
  localparam int FULL_OFS_RST = 127;
  localparam int NPIN = 34;
  localparam int BUS_W = 18;
  localparam int UNIT_W = 9;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CF_OW = 0;
  localparam int CF_IW = 1;
  localparam int CF_PFM = 2;
  localparam int CF_RM = 3;
  localparam int CF_PREF = 4;
  localparam int CF_RASY = 5;
  localparam int CF_WASY = 6;
  localparam int ST_AE = 0;
  localparam int ST_AF = 1;
  localparam int ST_FLAG = 2;
  localparam int ST_VALID = 3;
  localparam int ST_CNT = 8;
endpackage

// File: dcbmf_fifo_ctrl.sv
// Dual-clock bus-matching FIFO controller with APB status and offset access
//
// Contract
// - Output width strap: low x18, high x9
// - Almost-empty high once count reaches offset
// - Almost-full high while free exceeds offset
// - Flag timing strap: low async, high sync
// - Partial reset clears pointers, output; keeps settings
// - x9 read drives only low nine bits
// - Reads happen only with read enable
// - Sync read edge pops next word
// - Offset access reads give offset registers
// - Async read strobe pops; enable held low
// - Replay strap: low zero, high normal latency
// - Retransmit rewinds read pointer, forces flag
// - Serial offset load only with shift enable
// - Sync write edge with enable stores word
// - Async write strobe stores; enable held active
// - Writes happen only with write enable
// - Flag shows data ready, or empty when prefetching
// - Input width strap: low x18, high x9
module dcbmf_fifo_ctrl
  import dcbmf_pkg::*;
#(
  parameter int AW = 18
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic writeClock,
  input wire logic readClock,
  input wire logic writeEnableN,
  input wire logic readEnableN,
  input wire logic offsetAccessEnableN,
  input wire logic offsetShiftEnableN,
  input wire logic serialIn,
  input wire logic masterResetN,
  input wire logic partialResetN,
  input wire logic retransmitRequestN,
  input wire logic outputWidthSelect,
  input wire logic inputWidthSelect,
  input wire logic flagTimingSelect,
  input wire logic replayLatencySelect,
  input wire logic readSyncSelect,
  input wire logic writeSyncSelect,
  input wire logic [BUS_W-1:0] writeData,
  output logic [BUS_W-1:0] readDataBus,
  output logic almostEmptyFlag,
  output logic almostFullFlag,
  output logic emptyIndicator
);
  localparam logic [AW:0] DEPTH_U = (AW+1)'(1) << AW;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [NPIN-1:0] pinsRaw, s1, s2, s3, filt, next_filt;
  logic [BUS_W-1:0] wData;
  logic wAsyN, rAsyN, rmSel, pfmSel, iwSel, owSel, rtN, prsN, mrsN;
  logic siLvl, senN, ldN, renN, wenN, rClk, wClk, wrEdge, rdEdge;

  assign pinsRaw = {writeData, writeSyncSelect, readSyncSelect, replayLatencySelect,
    flagTimingSelect, inputWidthSelect, outputWidthSelect, retransmitRequestN,
    partialResetN, masterResetN, serialIn, offsetShiftEnableN, offsetAccessEnableN,
    readEnableN, writeEnableN, readClock, writeClock};
  // Data from the third stage, aligned with the clock samples
  assign {wData, wAsyN, rAsyN, rmSel, pfmSel, iwSel, owSel, rtN, prsN, mrsN, siLvl,
    senN, ldN, renN, wenN, rClk, wClk} = {s3[NPIN-1:16], filt[15:0]};

  // A level counts once the second and third stages agree
  always_comb begin
    next_filt = (s2 & s3) | (filt & (s2 | s3));
  end
  assign wrEdge = next_filt[0] & ~wClk;
  assign rdEdge = next_filt[1] & ~rClk;

  // Synchroniser stages
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      filt <= '0;
    end else begin
      s1 <= pinsRaw;
      s2 <= s1;
      s3 <= s2;
      filt <= next_filt;
    end
  end

  // ----------------------------------------
  // FIFO core
  // ----------------------------------------
  logic [UNIT_W-1:0] mem [0:(1<<AW)-1];
  logic [AW-1:0] wp, rp, next_wp, next_rp, emptyOfs, fullOfs, next_emptyOfs, next_fullOfs;
  logic [AW:0] cnt, next_cnt, wUnits, rUnits, freeU, freeW, wordsR;
  logic [BUS_W-1:0] readData, next_readData, rdWord;
  logic outValid, next_outValid, holdoff, next_holdoff, ofsWrHi, next_ofsWrHi;
  logic ofsRdHi, next_ofsRdHi, aeFlag, next_aeFlag, afFlag, next_afFlag;
  logic flagInd, next_flagInd;
  logic owX9, iwX9, pfmSync, rmNormal, prefetch, rdAsync, wrAsync;
  logic next_owX9, next_iwX9, next_pfmSync, next_rmNormal, next_prefetch;
  logic next_rdAsync, next_wrAsync;
  logic wrEn, rdEn, doWrData, doWrOfs, doRdData, doRdOfs, rtEvt, pop;
  logic apbWrE, apbWrF;

  // Words read in x18 mode take two units, low half first
  always_comb begin
    rdWord = {BUS_W{1'b0}};
    rdWord[UNIT_W-1:0] = mem[rp];
    if (!owX9) begin
      rdWord[BUS_W-1:UNIT_W] = mem[rp + AW'(1)];
    end
  end

  // Next state of pointers, output, flags and offsets
  always_comb begin
    next_wp = wp;
    next_rp = rp;
    next_cnt = cnt;
    next_readData = readData;
    next_outValid = outValid;
    next_holdoff = 1'b0;
    next_ofsWrHi = ofsWrHi;
    next_ofsRdHi = ofsRdHi;
    next_emptyOfs = emptyOfs;
    next_fullOfs = fullOfs;
    next_aeFlag = aeFlag;
    next_afFlag = afFlag;
    next_owX9 = owX9;
    next_iwX9 = iwX9;
    next_pfmSync = pfmSync;
    next_rmNormal = rmNormal;
    next_prefetch = prefetch;
    next_rdAsync = rdAsync;
    next_wrAsync = wrAsync;
    wUnits = iwX9 ? (AW+1)'(1) : (AW+1)'(2);
    rUnits = owX9 ? (AW+1)'(1) : (AW+1)'(2);
    freeU = DEPTH_U - cnt;
    freeW = iwX9 ? freeU : (freeU >> 1);
    wordsR = owX9 ? cnt : (cnt >> 1);
    wrEn = wrEdge & (wrAsync | ~wenN);
    rdEn = rdEdge & (rdAsync | ~renN);
    doWrData = wrEn & ldN & (freeU >= wUnits);
    doWrOfs = wrEn & ~ldN;
    doRdData = rdEn & ldN;
    doRdOfs = rdEn & ~ldN;
    rtEvt = rdEdge & ~rtN;
    pop = (cnt >= rUnits) & ~holdoff & ~rtEvt &
      (prefetch ? (~outValid | doRdData) : doRdData);
    if (prefetch && doRdData && !pop) begin
      next_outValid = 1'b0;
    end
    if (pop) begin
      next_readData = rdWord;
      next_rp = rp + rUnits[AW-1:0];
      next_outValid = 1'b1;
    end
    // Offset registers on the outputs, empty offset first
    if (doRdOfs) begin
      next_readData = BUS_W'(ofsRdHi ? fullOfs : emptyOfs);
      if (owX9) begin
        next_readData[BUS_W-1:UNIT_W] = '0;
      end
      next_ofsRdHi = ~ofsRdHi;
    end
    if (doWrData) begin
      next_wp = wp + wUnits[AW-1:0];
    end
    next_cnt = cnt + (doWrData ? wUnits : '0) - (pop ? rUnits : '0);
    // Replay from the first location
    if (rtEvt) begin
      next_rp = '0;
      next_cnt = {1'b0, next_wp};
      next_outValid = 1'b0;
      next_holdoff = rmNormal;
    end
    // Offset writes: bus first, then pins
    if (apbWrE) begin
      next_emptyOfs = pwdata[AW-1:0];
    end
    if (apbWrF) begin
      next_fullOfs = pwdata[AW-1:0];
    end
    if (doWrOfs) begin
      if (ofsWrHi) begin
        next_fullOfs = AW'(wData);
      end else begin
        next_emptyOfs = AW'(wData);
      end
      next_ofsWrHi = ~ofsWrHi;
    end
    if (wrEdge && !senN) begin
      {next_fullOfs, next_emptyOfs} = {fullOfs[AW-2:0], emptyOfs, siLvl};
    end
    // Flags follow the count at once, or on their own port edge
    if (!pfmSync || rdEdge) begin
      next_aeFlag = wordsR >= {1'b0, emptyOfs};
    end
    if (!pfmSync || wrEdge) begin
      next_afFlag = freeW > {1'b0, fullOfs};
    end
    next_flagInd = prefetch ? ~next_outValid : (next_cnt >= rUnits);
    if (rtEvt || next_holdoff) begin
      next_flagInd = prefetch;
    end
    // Either reset empties the store; only partial reset keeps settings
    if (!prsN || !mrsN) begin
      next_wp = '0;
      next_rp = '0;
      next_cnt = '0;
      next_readData = '0;
      next_outValid = 1'b0;
      next_holdoff = 1'b0;
      next_ofsWrHi = 1'b0;
      next_ofsRdHi = 1'b0;
      next_aeFlag = 1'b0;
      next_afFlag = 1'b1;
      next_flagInd = prefetch;
    end
    // Straps and default offsets caught during master reset
    if (!mrsN) begin
      next_owX9 = owSel;
      next_iwX9 = iwSel;
      next_pfmSync = pfmSel;
      next_rmNormal = rmSel;
      next_prefetch = siLvl;
      next_flagInd = siLvl;
      next_rdAsync = ~rAsyN;
      next_wrAsync = ~wAsyN;
      next_emptyOfs = AW'(EMPTY_OFS_RST);
      next_fullOfs = AW'(FULL_OFS_RST);
    end
  end

  // Data store
  always_ff @(posedge mclk) begin
    if (doWrData && prsN && mrsN) begin
      mem[wp] <= wData[UNIT_W-1:0];
      if (!iwX9) begin
        mem[wp + AW'(1)] <= wData[BUS_W-1:UNIT_W];
      end
    end
  end

  // Core registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
      readData <= '0;
      outValid <= 1'b0;
      holdoff <= 1'b0;
      ofsWrHi <= 1'b0;
      ofsRdHi <= 1'b0;
      emptyOfs <= AW'(EMPTY_OFS_RST);
      fullOfs <= AW'(FULL_OFS_RST);
      aeFlag <= 1'b0;
      afFlag <= 1'b1;
      flagInd <= 1'b0;
      owX9 <= 1'b0;
      iwX9 <= 1'b0;
      pfmSync <= 1'b0;
      rmNormal <= 1'b0;
      prefetch <= 1'b0;
      rdAsync <= 1'b0;
      wrAsync <= 1'b0;
    end else begin
      wp <= next_wp;
      rp <= next_rp;
      cnt <= next_cnt;
      readData <= next_readData;
      outValid <= next_outValid;
      holdoff <= next_holdoff;
      ofsWrHi <= next_ofsWrHi;
      ofsRdHi <= next_ofsRdHi;
      emptyOfs <= next_emptyOfs;
      fullOfs <= next_fullOfs;
      aeFlag <= next_aeFlag;
      afFlag <= next_afFlag;
      flagInd <= next_flagInd;
      owX9 <= next_owX9;
      iwX9 <= next_iwX9;
      pfmSync <= next_pfmSync;
      rmNormal <= next_rmNormal;
      prefetch <= next_prefetch;
      rdAsync <= next_rdAsync;
      wrAsync <= next_wrAsync;
    end
  end

  assign readDataBus = readData;
  assign almostEmptyFlag = aeFlag;
  assign almostFullFlag = afFlag;
  assign emptyIndicator = flagInd;

  // ----------------------------------------
  // APB slave, one wait state
  // ----------------------------------------
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr;

  assign apbWrE = psel & penable & pready & pwrite & (paddr == ADDR_EMPTY_OFS);
  assign apbWrF = psel & penable & pready & pwrite & (paddr == ADDR_FULL_OFS);

  // Read data and error prepared with the ready
  always_comb begin
    next_pready = psel & penable & ~pready;
    next_prdata = '0;
    next_pslverr = 1'b0;
    if (next_pready && !pwrite) begin
      case (paddr)
        ADDR_CONFIG: begin
          next_prdata[CF_OW] = owX9;
          next_prdata[CF_IW] = iwX9;
          next_prdata[CF_PFM] = pfmSync;
          next_prdata[CF_RM] = rmNormal;
          next_prdata[CF_PREF] = prefetch;
          next_prdata[CF_RASY] = rdAsync;
          next_prdata[CF_WASY] = wrAsync;
        end
        ADDR_EMPTY_OFS: next_prdata = 32'(emptyOfs);
        ADDR_FULL_OFS: next_prdata = 32'(fullOfs);
        ADDR_STATUS: begin
          next_prdata[ST_AE] = aeFlag;
          next_prdata[ST_AF] = afFlag;
          next_prdata[ST_FLAG] = flagInd;
          next_prdata[ST_VALID] = outValid;
          next_prdata[ST_CNT +: AW+1] = cnt;
        end
        default: next_pslverr = 1'b1;
      endcase
    end else if (next_pready) begin
      next_pslverr = (paddr != ADDR_EMPTY_OFS) && (paddr != ADDR_FULL_OFS);
    end
  end

  // APB answer registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end else begin
      pready <= next_pready;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  AST_X9_HIGH_ZERO: assert property (@(posedge mclk) disable iff (!rst_n)
    owX9 && $stable(owX9) |-> readData[BUS_W-1:UNIT_W] == '0)
    else $error("upper read bits driven in x9 mode");
  AST_AE_ASYNC: assert property (@(posedge mclk) disable iff (!rst_n)
    !pfmSync && mrsN && prsN |=> aeFlag == ($past(wordsR) >= {1'b0, $past(emptyOfs)}))
    else $error("almost-empty flag wrong");
  AST_AF_ASYNC: assert property (@(posedge mclk) disable iff (!rst_n)
    !pfmSync && mrsN && prsN |=> afFlag == ($past(freeW) > {1'b0, $past(fullOfs)}))
    else $error("almost-full flag wrong");
  AST_PARTIAL_RESET: assert property (@(posedge mclk) disable iff (!rst_n)
    !prsN |=> wp == '0 && rp == '0 && readData == '0 && $stable(emptyOfs))
    else $error("partial reset did not clear store");
  AST_RETRANSMIT: assert property (@(posedge mclk) disable iff (!rst_n)
    rtEvt && prsN && mrsN |=> rp == '0 && flagInd == prefetch)
    else $error("retransmit did not rewind");
  AST_NO_READ: assert property (@(posedge mclk) disable iff (!rst_n)
    rdEdge && renN && !rdAsync && !prefetch && !rtEvt && prsN && mrsN |=> $stable(rp))
    else $error("read without enable");
  AST_SYNC_POP: assert property (@(posedge mclk) disable iff (!rst_n)
    doRdData && !prefetch && !holdoff && !rtEvt && cnt >= rUnits && prsN && mrsN
    |=> rp == $past(rp) + $past(rUnits[AW-1:0]))
    else $error("enabled read did not pop");
  AST_WRITE: assert property (@(posedge mclk) disable iff (!rst_n)
    doWrData && prsN && mrsN |=> wp == $past(wp) + $past(wUnits[AW-1:0]))
    else $error("enabled write did not store");
  AST_NO_WRITE: assert property (@(posedge mclk) disable iff (!rst_n)
    wrEdge && wenN && !wrAsync && prsN && mrsN |=> $stable(wp))
    else $error("write without enable");
  AST_SERIAL_GATE: assert property (@(posedge mclk) disable iff (!rst_n)
    senN && ldN && mrsN && !apbWrE && !apbWrF |=> $stable(emptyOfs) && $stable(fullOfs))
    else $error("offsets changed without shift enable");
endmodule // dcbmf_fifo_ctrl

// File: dcbmf_link_model.sv
// Link-side writer and reader model driving the FIFO's write and read ports
module dcbmf_link_model
  import dcbmf_pkg::*;
(
  input wire logic mclk,
  output logic writeClock,
  output logic readClock,
  output logic writeEnableN,
  output logic readEnableN,
  output logic [BUS_W-1:0] writeData,
  output logic popDone
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // Idle state: link clocks stand still low
  // ----------------------------------------
  initial begin
    writeClock = 1'b0;
    readClock = 1'b0;
    writeEnableN = 1'b1;
    readEnableN = 1'b1;
    writeData = '0;
    popDone = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // One 400 ns write cycle: four mclk high, four low
  task automatic push(input logic [BUS_W-1:0] d);
    tick(1);
    writeData <= d;
    writeEnableN <= 1'b0;
    tick(1);
    writeClock <= 1'b1;
    tick(4);
    writeClock <= 1'b0;
    tick(1);
    writeEnableN <= 1'b1;
    writeData <= ~d; // Released bus shows inverse
    tick(1);
  endtask
  // One 400 ns read cycle; en low gives an edge with no read
  task automatic pop(input logic en);
    tick(1);
    readEnableN <= ~en;
    tick(1);
    readClock <= 1'b1;
    tick(4);
    readClock <= 1'b0;
    tick(1);
    readEnableN <= 1'b1;
    popDone <= en;
    tick(1);
    popDone <= 1'b0;
  endtask
endmodule // dcbmf_link_model

// File: tb_top.sv
// Self-checking bench for the dual-clock FIFO controller
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_fail++; \
  $display("Error %0t: got %h exp %h", $time, a, e); end end
module tb_top
  import dcbmf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, seed = 32;
  logic pready, pslverr, almostEmptyFlag, almostFullFlag, emptyIndicator, popDone;
  logic writeClock, readClock, writeEnableN, readEnableN;
  localparam int TB_AW = 6;
  logic masterResetN = 1, partialResetN = 1, retransmitRequestN = 1;
  logic offsetAccessEnableN = 1, offsetShiftEnableN = 1, serialIn = 0;
  logic readSyncSelect = 1, writeSyncSelect = 1;
  logic ow = 0, iw = 0, flag_timing_select = 0, rm = 0;
  logic [BUS_W-1:0] writeData, readDataBus, w0, w1, w2;
  logic [64:0] ent;
  logic [64:0] qA[$];
  logic [BUS_W-1:0] qR[$];
  int n_fail = 0, n_checks = 0;
  always #25 mclk = ~mclk;
  dcbmf_link_model u_link (.mclk(mclk), .writeClock(writeClock), .readClock(readClock),
    .writeEnableN(writeEnableN), .readEnableN(readEnableN), .writeData(writeData),
    .popDone(popDone));
  dcbmf_fifo_ctrl #(.AW(TB_AW)) u_dut (.mclk(mclk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .writeClock(writeClock), .readClock(readClock),
    .writeEnableN(writeEnableN), .readEnableN(readEnableN),
    .offsetAccessEnableN(offsetAccessEnableN),
    .offsetShiftEnableN(offsetShiftEnableN), .serialIn(serialIn), .masterResetN(masterResetN),
    .partialResetN(partialResetN), .retransmitRequestN(retransmitRequestN),
    .outputWidthSelect(ow), .inputWidthSelect(iw), .flagTimingSelect(flag_timing_select),
    .replayLatencySelect(rm), .readSyncSelect(readSyncSelect),
    .writeSyncSelect(writeSyncSelect),
    .writeData(writeData), .readDataBus(readDataBus), .almostEmptyFlag(almostEmptyFlag),
    .almostFullFlag(almostFullFlag), .emptyIndicator(emptyIndicator));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // APB transfer; expected read data under mask and error are queued
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [31:0] e, input logic [31:0] m, input logic err);
    int i;
    qA.push_back({e & m, m, err});
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge mclk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_fail++;
      conclude();
    end
  endtask
  // Strap capture under master reset
  task automatic master_reset(input logic o, input logic iwv, input logic p, input logic r,
                     input logic s, input logic rs, input logic ws);
    @(posedge mclk);
    {ow, iw, flag_timing_select, rm} <= {o, iwv, p, r};
    {serialIn, readSyncSelect, writeSyncSelect} <= {s, rs, ws};
    masterResetN <= 1'b0;
    repeat (6) @(posedge mclk);
    masterResetN <= 1'b1;
    repeat (6) @(posedge mclk);
  endtask
  task automatic popx(input logic [BUS_W-1:0] e);
    qR.push_back(e);
    u_link.pop(1'b1);
  endtask
  // ----------------------------------------
  // Monitor: oldest note against each result
  // ----------------------------------------
  always @(posedge mclk) begin
    if (pready === 1'b1) begin
      ent = qA.size() ? qA.pop_front() : '1;
      `CHK(prdata & ent[32:1], ent[64:33])
      `CHK(pslverr, ent[0])
    end
    if (popDone === 1'b1) begin
      `CHK(readDataBus, qR.size() ? qR.pop_front() : 18'h3FFFF)
    end
  end
  // ----------------------------------------
  // Stimulus
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    seed = xs(seed);
    w0 = seed[17:0];
    seed = xs(seed);
    w1 = seed[17:0];
    seed = xs(seed);
    w2 = seed[17:0];
    master_reset(0, 0, 0, 0, 0, 1, 1);
    apb(0, ADDR_CONFIG, 0, 32'h0, 32'h7F, 0);
    apb(1, ADDR_EMPTY_OFS, 2, 0, 0, 0);
    apb(1, ADDR_FULL_OFS, 30, 0, 0, 0);
    apb(0, ADDR_EMPTY_OFS, 0, 32'h2, 32'h3F, 0);
    apb(0, 12'h010, 0, 32'h0, 32'hFFFFFFFF, 1);
    apb(1, ADDR_CONFIG, 32'h7F, 0, 0, 1);
    u_link.push(w0);
    `CHK(almostEmptyFlag, 1'b0)
    `CHK(almostFullFlag, 1'b1)
    u_link.push(w1);
    `CHK(almostEmptyFlag, 1'b1)
    `CHK(almostFullFlag, 1'b0)
    `CHK(emptyIndicator, 1'b1)
    apb(0, ADDR_STATUS, 0, 32'h405, 32'h7F0F, 0);
    u_link.pop(1'b0);
    `CHK(readDataBus, 18'h00000)
    popx(w0);
    @(posedge mclk);
    retransmitRequestN <= 1'b0;
    u_link.pop(1'b0);
    retransmitRequestN <= 1'b1;
    popx(w0);
    popx(w1);
    `CHK(emptyIndicator, 1'b0)
    @(posedge mclk);
    partialResetN <= 1'b0;
    repeat (6) @(posedge mclk);
    partialResetN <= 1'b1;
    repeat (6) @(posedge mclk);
    `CHK(readDataBus, 18'h00000)
    apb(0, ADDR_EMPTY_OFS, 0, 32'h2, 32'h3F, 0);
    apb(0, ADDR_STATUS, 0, 32'h2, 32'h7F0F, 0);
    // Serial shift of a one into the offset chain
    offsetShiftEnableN <= 1'b0;
    serialIn <= 1'b1;
    u_link.push(w1);
    offsetShiftEnableN <= 1'b1;
    apb(0, ADDR_EMPTY_OFS, 0, 32'h5, 32'h3F, 0);
    apb(0, ADDR_FULL_OFS, 0, 32'h3C, 32'h3F, 0);
    master_reset(1, 0, 1, 1, 0, 1, 1);
    apb(0, ADDR_CONFIG, 0, 32'hD, 32'h7F, 0);
    u_link.push(w2);
    popx({9'h000, w2[8:0]});
    popx({9'h000, w2[17:9]});
    // Offset registers on the read port, empty first
    offsetAccessEnableN <= 1'b0;
    popx(BUS_W'(EMPTY_OFS_RST % (1 << TB_AW)));
    popx(BUS_W'(FULL_OFS_RST % (1 << TB_AW)));
    offsetAccessEnableN <= 1'b1;
    // Prefetch mode: first word falls through
    master_reset(0, 0, 0, 0, 1, 1, 1);
    apb(0, ADDR_CONFIG, 0, 32'h10, 32'h7F, 0);
    u_link.push(w0);
    `CHK(emptyIndicator, 1'b0)
    `CHK(readDataBus, w0)
    popx(w0);
    `CHK(emptyIndicator, 1'b1)
    // Strobe-mode ports on both sides
    master_reset(0, 0, 0, 0, 0, 0, 0);
    apb(0, ADDR_CONFIG, 0, 32'h60, 32'h7F, 0);
    u_link.push(w2);
    popx(w2);
    repeat (4) @(posedge mclk);
    conclude();
  end
endmodule // tb_top
